// File: pkg/pcl_pkg.sv
package pcl_pkg;

	// ==================================================
	// datapath widths
	localparam int PCL_POS_W        = 16;
	localparam int PCL_FRAC_W       = 13;
	localparam int PCL_NUM_PTS      = 9;
	localparam int PCL_CORR_W       = 8;
	localparam int PCL_CORR_SHIFT   = 5;
	localparam int PCL_SLOPE_FRAC   = 10;
	localparam int PCL_SLOPE_W      = 12;
	localparam int PCL_SLOPE_POL    = 12;
	localparam int PCL_COIL_W       = 9;
	localparam int PCL_CH_W         = 16;

	localparam logic signed [PCL_COIL_W-1:0] PCL_COIL_MAX = 9'sh0FC;
	localparam logic signed [PCL_COIL_W-1:0] PCL_COIL_MIN = -9'sh0FC;
	localparam logic [PCL_POS_W-1:0]         PCL_POS_MAX  = 16'hFFFF;
	localparam logic signed [PCL_CORR_W-1:0] PCL_CORR_LIM = 8'sh7F;

	// ==================================================
	// zero offset word decode
	localparam int                   PCL_ZERO_LIN_BIT = 13;
	localparam int                   PCL_ZERO_SH      = 5;
	localparam int                   PCL_ZERO_FLD_W   = 11;
	localparam logic [PCL_POS_W-1:0] PCL_ZERO_MID     = 16'h8000;

	// ==================================================
	// reset values
	localparam logic [15:0] PCL_ZERO_RST  = 16'h2400;
	localparam logic [15:0] PCL_SLOPE_RST = 16'h0400;

	// ==================================================
	// register indices (byte address is four times the index)
	localparam int         PCL_ADDR_LSB   = 2;
	localparam int         PCL_IDX_W      = 8;
	localparam logic [7:0] PCL_IDX_ZERO   = 8'h00;
	localparam logic [7:0] PCL_IDX_SLOPE  = 8'h01;
	localparam logic [7:0] PCL_IDX_PTW_LO = 8'h03;
	localparam logic [7:0] PCL_IDX_PTW_HI = 8'h07;
	localparam logic [7:0] PCL_IDX_COILS  = 8'h08;
	localparam logic [7:0] PCL_IDX_COILC  = 8'h09;
	localparam logic [7:0] PCL_IDX_CTRL   = 8'h0A;
	localparam logic [7:0] PCL_IDX_SPA    = 8'h18;
	localparam logic [7:0] PCL_IDX_CAL    = 8'h19;
	localparam logic [7:0] PCL_IDX_LIN    = 8'h1A;
	localparam int         PCL_CTRL_WRAP  = 0;

	// ==================================================
	// arctangent engine
	localparam int                   PCL_ITER     = 14;
	localparam logic [PCL_POS_W-1:0] PCL_ANG_HALF = 16'h8000;
	localparam logic [PCL_POS_W-1:0] PCL_ATAN [PCL_ITER] = '{
		16'h2000, 16'h12E4, 16'h09FB, 16'h0511, 16'h028B, 16'h0146, 16'h00A3,
		16'h0051, 16'h0029, 16'h0014, 16'h000A, 16'h0005, 16'h0003, 16'h0001
	};

	// ==================================================
	// bus carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} pcl_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pcl_apb_rsp_t;

	typedef logic [PCL_NUM_PTS-1:0][PCL_CORR_W-1:0] pcl_corr_t;

endpackage

// File: verilog/pcl_atan.sv
`timescale 1ns/1ns
module pcl_atan #(
	parameter int CH_W = pcl_pkg::PCL_CH_W
) (
	input  wire logic                           clk_i,
	input  wire logic                           sys_rst_i,
	input  wire logic                           start_i,
	input  wire logic signed [CH_W:0]           sin_i,
	input  wire logic signed [CH_W:0]           cos_i,
	output logic                                busy_o,
	output logic                                done_o,
	output logic        [pcl_pkg::PCL_POS_W-1:0] angle_o
);
	import pcl_pkg::*;

	localparam int XW = CH_W + 4;

	typedef enum logic {PCL_IDLE, PCL_RUN} pcl_atan_st_t;

	pcl_atan_st_t         st_q;
	logic [3:0]           it_q;
	logic signed [XW-1:0] x_q;
	logic signed [XW-1:0] y_q;
	logic [PCL_POS_W-1:0] z_q;
	logic signed [XW-1:0] xs;
	logic signed [XW-1:0] ys;
	logic signed [XW-1:0] xe;
	logic signed [XW-1:0] ye;

	assign xs     = x_q >>> it_q;
	assign ys     = y_q >>> it_q;
	assign xe     = XW'(cos_i);
	assign ye     = XW'(sin_i);
	assign busy_o = (st_q == PCL_RUN);

	// ==================================================
	// vectoring iterations
	// arctangent of channels
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_q <= PCL_IDLE;
			it_q <= 4'h0;
			x_q  <= '0;
			y_q  <= '0;
			z_q  <= '0;
		end else begin
			case (st_q)
				PCL_IDLE: begin
					if (start_i) begin
						st_q <= PCL_RUN;
						it_q <= 4'h0;
						x_q  <= xe[XW-1] ? -xe : xe;
						y_q  <= xe[XW-1] ? -ye : ye;
						z_q  <= xe[XW-1] ? PCL_ANG_HALF : '0;
					end
				end
				PCL_RUN: begin
					if (y_q[XW-1]) begin
						x_q <= x_q - ys;
						y_q <= y_q + xs;
						z_q <= z_q - PCL_ATAN[it_q];
					end else begin
						x_q <= x_q + ys;
						y_q <= y_q - xs;
						z_q <= z_q + PCL_ATAN[it_q];
					end
					if (it_q == 4'(PCL_ITER - 1)) begin
						st_q <= PCL_IDLE;
					end
					it_q <= it_q + 4'h1;
				end
				default: st_q <= PCL_IDLE;
			endcase
		end
	end

	// ==================================================
	// result
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			done_o  <= 1'b0;
			angle_o <= '0;
		end else begin
			done_o <= (st_q == PCL_RUN) && (it_q == 4'(PCL_ITER - 1));
			if ((st_q == PCL_RUN) && (it_q == 4'(PCL_ITER - 1))) begin
				angle_o <= y_q[XW-1] ? z_q - PCL_ATAN[it_q] : z_q + PCL_ATAN[it_q];
			end
		end
	end

endmodule

// File: verilog/pcl_interp.sv
`timescale 1ns/1ns
module pcl_interp (
	input  wire logic [pcl_pkg::PCL_POS_W-1:0] cal_i,
	input  wire pcl_pkg::pcl_corr_t            corr_i,
	output logic      [pcl_pkg::PCL_POS_W-1:0] lin_o
);
	import pcl_pkg::*;

	logic [2:0]             sec;
	logic [3:0]             sec_n;
	logic [PCL_FRAC_W-1:0]  frac;
	logic signed [23:0]     a_ext;
	logic signed [23:0]     b_ext;
	logic signed [23:0]     prod;
	logic signed [23:0]     acc;
	logic signed [23:0]     corr;
	logic signed [23:0]     sum;

	assign sec   = cal_i[PCL_POS_W-1:PCL_FRAC_W];
	assign frac  = cal_i[PCL_FRAC_W-1:0];
	assign sec_n = {1'b0, sec} + 4'h1;
	assign a_ext = 24'(signed'(corr_i[sec]));
	assign b_ext = 24'(signed'(corr_i[sec_n]));

	assign prod = (b_ext - a_ext) * $signed({11'h000, frac});
	assign acc  = (a_ext <<< PCL_FRAC_W) + prod;
	assign corr = acc >>> (PCL_FRAC_W - PCL_CORR_SHIFT);
	assign sum  = $signed({8'h00, cal_i}) + corr;

	always_comb begin
		if (sum < 0) begin
			lin_o = '0;
		end else if (sum > $signed({8'h00, PCL_POS_MAX})) begin
			lin_o = PCL_POS_MAX;
		end else begin
			lin_o = sum[PCL_POS_W-1:0];
		end
	end

endmodule

// File: verilog/pcl_position_linearizer.sv
// Summary of operation
// - The calibrated position is an unsigned 16-bit value covering codes 0 to 65535.
// - The calibrated position is read-only at register index 19h and writes there change nothing.
// - The 16-bit range is cut into eight equal sections of 8192 codes whose ends are the points.
// - The nine points sit at fixed x positions k times 8192 and only their y values are set.
// - The y corrections come from the configuration words at indices 03h to 07h.
// - Each correction is a signed value of at most 127 weighted at the eleven top position bits.
// - Inside a section the correction is interpolated linearly between its two end points.
// - The corrected position is kept and readable in its own linearized position register.
// - The calibrated position is the raw angle minus the zero offset, times the slope factor.
// - The raw angle is the arctangent of the sine and cosine receiver channels.
// - The slope factor reaches at most four; larger gains cannot be encoded.
// - A coil offset of at most 252 in magnitude is subtracted from each raw channel.
// - With zero offset, unity slope and no corrections all three positions are equal.
// - Word 00h encodes zero offset as 2400h in linear mode, 0000h in wrap mode; word 01h unity as 0400h.
// - The raw angle register holds the position after the coil offsets but before zero offset, slope or correction.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module pcl_position_linearizer #(
	parameter int CH_W = pcl_pkg::PCL_CH_W
) (
	input  wire logic                              clk_i,
	input  wire logic                              sys_rst_i,
	input  wire pcl_pkg::pcl_apb_req_t             apb_req_i,
	output pcl_pkg::pcl_apb_rsp_t                  apb_rsp_o,
	input  wire logic signed [CH_W-1:0]            sin_raw_i,
	input  wire logic signed [CH_W-1:0]            cos_raw_i,
	input  wire logic                              sample_valid_i,
	output logic                                   sample_ready_o,
	output logic        [pcl_pkg::PCL_POS_W-1:0]    calibrated_position_o,
	output logic        [pcl_pkg::PCL_POS_W-1:0]    linearized_position_o,
	output logic                                   position_valid_o
);
	import pcl_pkg::*;

	// ==================================================
	// declarations
	logic [15:0]                   zero_offset_word_q;
	logic [15:0]                   slope_word_q;
	pcl_corr_t                     corr_q;
	logic signed [PCL_COIL_W-1:0]  coil_sin_q;
	logic signed [PCL_COIL_W-1:0]  coil_cos_q;
	logic                          wrap_mode_q;
	logic [PCL_POS_W-1:0]          spatial_angle_q;
	logic                          spa_vld_q;
	logic [PCL_POS_W-1:0]          calibrated_position_q;
	logic                          cal_vld_q;
	logic [PCL_POS_W-1:0]          linearized_position_q;
	logic                          lin_vld_q;
	logic [31:0]                   prdata_q;
	logic                          pslverr_q;

	logic                          setup;
	logic                          wr_acc;
	logic [PCL_IDX_W-1:0]          idx;
	logic                          upper_zero;
	logic [31:0]                   rd_data;
	logic                          rd_hit;
	logic signed [PCL_COIL_W-1:0]  wr_coil;

	logic signed [CH_W:0]          sin_comp;
	logic signed [CH_W:0]          cos_comp;
	logic                          start;
	logic                          atan_busy;
	logic                          atan_done;
	logic [PCL_POS_W-1:0]          atan_angle;

	logic [PCL_POS_W-1:0]          zero_off;
	logic [PCL_POS_W:0]            diff;
	logic [PCL_POS_W-1:0]          diff_eff;
	logic [27:0]                   scaled;
	logic [17:0]                   cal_wide;
	logic [PCL_POS_W-1:0]          cal_next;
	logic [PCL_POS_W-1:0]          lin_next;

	// ==================================================
	// bus decode
	assign setup      = apb_req_i.psel && !apb_req_i.penable;
	assign wr_acc     = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && !pslverr_q;
	assign idx        = apb_req_i.paddr[PCL_ADDR_LSB +: PCL_IDX_W];
	assign upper_zero = (apb_req_i.paddr[31:PCL_ADDR_LSB+PCL_IDX_W] == '0) &&
	                    (apb_req_i.paddr[PCL_ADDR_LSB-1:0] == '0);

	// zero wait states: data and error are prepared in the setup cycle
	assign apb_rsp_o.pready  = 1'b1;
	assign apb_rsp_o.pslverr = pslverr_q;
	assign apb_rsp_o.prdata  = prdata_q;

	always_comb begin
		if ($signed(apb_req_i.pwdata[PCL_COIL_W-1:0]) > PCL_COIL_MAX) begin
			wr_coil = PCL_COIL_MAX;
		end else if ($signed(apb_req_i.pwdata[PCL_COIL_W-1:0]) < PCL_COIL_MIN) begin
			wr_coil = PCL_COIL_MIN;
		end else begin
			wr_coil = $signed(apb_req_i.pwdata[PCL_COIL_W-1:0]);
		end
	end

	// ==================================================
	// read mux
	always_comb begin
		rd_data = '0;
		rd_hit  = 1'b1;
		case (idx)
			PCL_IDX_ZERO:  rd_data = {16'h0000, zero_offset_word_q};
			PCL_IDX_SLOPE: rd_data = {16'h0000, slope_word_q};
			PCL_IDX_COILS: rd_data = {{(32-PCL_COIL_W){coil_sin_q[PCL_COIL_W-1]}}, coil_sin_q};
			PCL_IDX_COILC: rd_data = {{(32-PCL_COIL_W){coil_cos_q[PCL_COIL_W-1]}}, coil_cos_q};
			PCL_IDX_CTRL:  rd_data = {31'h00000000, wrap_mode_q};
			PCL_IDX_SPA:   rd_data = {16'h0000, spatial_angle_q};
			PCL_IDX_CAL:   rd_data = {16'h0000, calibrated_position_q};
			PCL_IDX_LIN:   rd_data = {16'h0000, linearized_position_q};
			default: begin
				if ((idx >= PCL_IDX_PTW_LO) && (idx <= PCL_IDX_PTW_HI)) begin
					for (int k = 0; k < PCL_NUM_PTS; k++) begin
						if (idx == PCL_IDX_PTW_LO + 8'(k / 2)) begin
							rd_data[(k % 2) * PCL_CORR_W +: PCL_CORR_W] = corr_q[k];
						end
					end
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
		if (!upper_zero) begin
			rd_hit = 1'b0;
		end
	end

	// ==================================================
	// bus response
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q  <= (rd_hit && !apb_req_i.pwrite) ? rd_data : '0;
			pslverr_q <= !rd_hit;
		end
	end

	// ==================================================
	// calibration words
	// identity reset values
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			zero_offset_word_q <= PCL_ZERO_RST;
		end else if (wr_acc && (idx == PCL_IDX_ZERO)) begin
			zero_offset_word_q <= apb_req_i.pwdata[15:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			slope_word_q <= PCL_SLOPE_RST;
		end else if (wr_acc && (idx == PCL_IDX_SLOPE)) begin
			slope_word_q <= {3'h0, apb_req_i.pwdata[PCL_SLOPE_POL:0]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			coil_sin_q <= '0;
			coil_cos_q <= '0;
		end else if (wr_acc && (idx == PCL_IDX_COILS)) begin
			coil_sin_q <= wr_coil;
		end else if (wr_acc && (idx == PCL_IDX_COILC)) begin
			coil_cos_q <= wr_coil;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wrap_mode_q <= 1'b0;
		end else if (wr_acc && (idx == PCL_IDX_CTRL)) begin
			wrap_mode_q <= apb_req_i.pwdata[PCL_CTRL_WRAP];
		end
	end

	// ==================================================
	// correction points, two per word
	for (genvar g = 0; g < PCL_NUM_PTS; g++) begin : g_corr
		logic signed [PCL_CORR_W-1:0] wr_pt;
		assign wr_pt = apb_req_i.pwdata[(g % 2) * PCL_CORR_W +: PCL_CORR_W];
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				corr_q[g] <= '0;
			end else if (wr_acc && (idx == PCL_IDX_PTW_LO + 8'(g / 2))) begin
				corr_q[g] <= (wr_pt < -PCL_CORR_LIM) ? -PCL_CORR_LIM : wr_pt;
			end
		end
	end

	// ==================================================
	// channel compensation and angle
	// subtract coil offset
	assign sin_comp = $signed({sin_raw_i[CH_W-1], sin_raw_i}) -
	                  $signed({{(CH_W+1-PCL_COIL_W){coil_sin_q[PCL_COIL_W-1]}}, coil_sin_q});
	assign cos_comp = $signed({cos_raw_i[CH_W-1], cos_raw_i}) -
	                  $signed({{(CH_W+1-PCL_COIL_W){coil_cos_q[PCL_COIL_W-1]}}, coil_cos_q});

	// samples offered while the engine runs are not taken
	assign start          = sample_valid_i && !atan_busy;
	assign sample_ready_o = !atan_busy;

	pcl_atan #(
		.CH_W (CH_W)
	) u_atan (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (start),
		.sin_i     (sin_comp),
		.cos_i     (cos_comp),
		.busy_o    (atan_busy),
		.done_o    (atan_done),
		.angle_o   (atan_angle)
	);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			spatial_angle_q <= '0;
			spa_vld_q       <= 1'b0;
		end else begin
			spa_vld_q <= atan_done;
			if (atan_done) begin
				spatial_angle_q <= atan_angle;
			end
		end
	end

	// ==================================================
	// zero offset and slope
	// zero offset word decode
	always_comb begin
		if (wrap_mode_q) begin
			zero_off = {zero_offset_word_q[PCL_ZERO_FLD_W-1:0], PCL_ZERO_SH'(0)};
		end else if (zero_offset_word_q[PCL_ZERO_LIN_BIT]) begin
			zero_off = PCL_ZERO_MID - {zero_offset_word_q[PCL_ZERO_FLD_W-1:0], PCL_ZERO_SH'(0)};
		end else begin
			zero_off = PCL_ZERO_MID + {zero_offset_word_q[PCL_ZERO_FLD_W-1:0], PCL_ZERO_SH'(0)};
		end
	end

	always_comb begin
		if (slope_word_q[PCL_SLOPE_POL]) begin
			diff = {1'b0, zero_off} - {1'b0, spatial_angle_q};
		end else begin
			diff = {1'b0, spatial_angle_q} - {1'b0, zero_off};
		end
		// linear mode stops at zero below the start point
		if (diff[PCL_POS_W] && !wrap_mode_q) begin
			diff_eff = '0;
		end else begin
			diff_eff = diff[PCL_POS_W-1:0];
		end
	end

	assign scaled   = diff_eff * slope_word_q[PCL_SLOPE_W-1:0];
	assign cal_wide = scaled[27:PCL_SLOPE_FRAC];

	always_comb begin
		if (cal_wide[17:PCL_POS_W] != 2'b00) begin
			cal_next = PCL_POS_MAX;
		end else begin
			cal_next = cal_wide[PCL_POS_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			calibrated_position_q <= '0;
			cal_vld_q             <= 1'b0;
		end else begin
			cal_vld_q <= spa_vld_q;
			if (spa_vld_q) begin
				calibrated_position_q <= cal_next;
			end
		end
	end

	// ==================================================
	// linearization
	pcl_interp u_interp (
		.cal_i  (calibrated_position_q),
		.corr_i (corr_q),
		.lin_o  (lin_next)
	);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			linearized_position_q <= '0;
			lin_vld_q             <= 1'b0;
		end else begin
			lin_vld_q <= cal_vld_q;
			if (cal_vld_q) begin
				linearized_position_q <= lin_next;
			end
		end
	end

	// ==================================================
	// outputs
	assign calibrated_position_o = calibrated_position_q;
	assign linearized_position_o = linearized_position_q;
	assign position_valid_o      = lin_vld_q;

endmodule

// File: sim/pcl_apb_host.sv
`timescale 1ns/1ns
module pcl_apb_host (
	input  wire logic                  clk_i,
	output pcl_pkg::pcl_apb_req_t      req_o,
	input  wire pcl_pkg::pcl_apb_rsp_t rsp_i
);
	import pcl_pkg::*;

	initial begin
		req_o = '0;
	end

	// ==================================================
	// one bus transfer, held until pready is sampled
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		n = 0;
		@(posedge clk_i);
		req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {22'h000000, idx, 2'h0}, pwdata: d};
		@(posedge clk_i);
		req_o.penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (rsp_i.pready !== 1'b1 && n < 20);
		q = rsp_i.prdata;
		e = rsp_i.pslverr;
		req_o <= '0;
		test_position_calibration_linearizer.bail(rsp_i.pready);
	endtask
endmodule

// File: sim/pcl_position_linearizer_asserts.sv
`timescale 1ns/1ns
module pcl_position_linearizer_asserts #(
	parameter int CH_W = pcl_pkg::PCL_CH_W
) (
	input  wire logic                           clk_i,
	input  wire logic                           sys_rst_i,
	input  wire pcl_pkg::pcl_apb_req_t          apb_req_i,
	input  wire pcl_pkg::pcl_apb_rsp_t          apb_rsp_o,
	input  wire logic signed [CH_W-1:0]         sin_raw_i,
	input  wire logic signed [CH_W-1:0]         cos_raw_i,
	input  wire logic                           sample_valid_i,
	input  wire logic                           sample_ready_o,
	input  wire logic [pcl_pkg::PCL_POS_W-1:0]  calibrated_position_o,
	input  wire logic [pcl_pkg::PCL_POS_W-1:0]  linearized_position_o,
	input  wire logic                           position_valid_o
);
	import pcl_pkg::*;

	logic take;
	logic rd_set;
	logic wr_set;
	assign take   = sample_valid_i & sample_ready_o;
	assign rd_set = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;
	assign wr_set = apb_req_i.psel & ~apb_req_i.penable & apb_req_i.pwrite;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// ==================================================
	// sample path
	property p_busy_window;
		take |=> !sample_ready_o [*8] ##1 !sample_ready_o [*6] ##1 sample_ready_o;
	endproperty
	a_busy_window: assert property (p_busy_window) else $error("ready wrong after sample take");
	property p_result_latency;
		take |-> ##18 position_valid_o;
	endproperty
	a_result_latency: assert property (p_result_latency) else $error("result not on time");
	property p_valid_pulse;
		position_valid_o |=> !position_valid_o;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");
	property p_hold;
		!position_valid_o |-> $stable(linearized_position_o);
	endproperty
	a_hold: assert property (p_hold) else $error("position changed without valid");
	property p_cal_lead;
		$changed(calibrated_position_o) |=> position_valid_o;
	endproperty
	a_cal_lead: assert property (p_cal_lead) else $error("calibrated change without valid");

	// ==================================================
	// register reads
	property p_cal_read;
		rd_set && apb_req_i.paddr == 32'h00000064 |=>
			apb_rsp_o.prdata == {16'h0000, $past(calibrated_position_o)} && !apb_rsp_o.pslverr;
	endproperty
	a_cal_read: assert property (p_cal_read) else $error("calibrated read mismatch");
	property p_lin_read;
		rd_set && apb_req_i.paddr == 32'h00000068 |=> apb_rsp_o.prdata == {16'h0000, $past(linearized_position_o)};
	endproperty
	a_lin_read: assert property (p_lin_read) else $error("linearized read mismatch");
	property p_ro_write;
		wr_set && apb_req_i.paddr == 32'h00000064 |=> !apb_rsp_o.pslverr;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write flagged");
	property p_slope_read;
		rd_set && apb_req_i.paddr == 32'h00000004 |=> apb_rsp_o.prdata[31:13] == 19'h00000;
	endproperty
	a_slope_read: assert property (p_slope_read) else $error("slope high bits set");
	property p_corr_read;
		rd_set && apb_req_i.paddr == 32'h0000001C |=> apb_rsp_o.prdata[31:8] == 24'h000000;
	endproperty
	a_corr_read: assert property (p_corr_read) else $error("last point word high bits set");
	property p_unmapped;
		(rd_set || wr_set) && apb_req_i.paddr == 32'h00000008 |=> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped word not refused");
	property p_coil_range;
		rd_set && apb_req_i.paddr == 32'h00000020 |=>
			$signed(apb_rsp_o.prdata) <= 32'sh000000FC && $signed(apb_rsp_o.prdata) >= -32'sh000000FC;
	endproperty
	a_coil_range: assert property (p_coil_range) else $error("coil offset out of range");
endmodule

bind pcl_position_linearizer pcl_position_linearizer_asserts #(.CH_W(CH_W)) pcl_position_linearizer_asserts_i (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .sin_raw_i(sin_raw_i),
	.cos_raw_i(cos_raw_i), .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
	.calibrated_position_o(calibrated_position_o), .linearized_position_o(linearized_position_o),
	.position_valid_o(position_valid_o));

// File: sim/test_position_calibration_linearizer.sv
`timescale 1ns/1ns
module test_position_calibration_linearizer;
	import pcl_pkg::*;
	logic               clk_i = 1'b0;
	logic               sys_rst_i = 1'b1;
	pcl_apb_req_t       apb_req;
	pcl_apb_rsp_t       apb_rsp;
	logic signed [15:0] sin_raw_i = 16'h0000;
	logic signed [15:0] cos_raw_i = 16'h0000;
	logic               sample_valid_i = 1'b0;
	logic               sample_ready;
	logic [15:0]        cal_pos;
	logic [15:0]        lin_pos;
	logic               pos_valid;
	int                 n_mismatch = 0;
	int                 checked = 0;
	int                 seed = 32'h592C;

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	pcl_apb_host pcl_apb_host_i (.clk_i(clk_i), .req_o(apb_req), .rsp_i(apb_rsp));
	pcl_position_linearizer #(.CH_W(16)) pcl_position_linearizer_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .apb_req_i(apb_req), .apb_rsp_o(apb_rsp),
		.sin_raw_i(sin_raw_i), .cos_raw_i(cos_raw_i), .sample_valid_i(sample_valid_i),
		.sample_ready_o(sample_ready), .calibrated_position_o(cal_pos),
		.linearized_position_o(lin_pos), .position_valid_o(pos_valid));

	// ==================================================
	// helpers
	task tally_and_finish;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task bail(input logic ok);
		if (ok !== 1'b1) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task rst;
		sys_rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		pcl_apb_host_i.xfer(1'b1, idx, d, q, e);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] q, output logic e);
		pcl_apb_host_i.xfer(1'b0, idx, 32'h00000000, q, e);
	endtask
	// one sample at angle code k, sine channel shifted by so
	task automatic smp(input logic [15:0] k, input int so, output logic [15:0] c, output logic [15:0] l);
		real th;
		int  n;
		th = k * 6.283185307179586 / 65536.0;
		n = 0;
		@(posedge clk_i);
		sin_raw_i <= 16'($rtoi(12000.0 * $sin(th)) + so);
		cos_raw_i <= 16'($rtoi(12000.0 * $cos(th)));
		sample_valid_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (sample_ready !== 1'b1 && n < 40);
		sample_valid_i <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pos_valid !== 1'b1 && n < 80);
		bail(pos_valid);
		c = cal_pos;
		l = lin_pos;
	endtask
	task automatic chk_ang(input logic [15:0] k, output logic [15:0] sp);
		logic [31:0] q;
		logic        e;
		logic [15:0] dif;
		rd(PCL_IDX_SPA, q, e);
		sp = q[15:0];
		dif = sp - k;
		check(dif <= 16'h0004 || dif >= 16'hFFFC, 32'h00000001);
	endtask
	function automatic logic [15:0] v2code(real v);
		return 16'($rtoi((v - 0.25) * 65535.0 / 4.5));
	endfunction
	function automatic logic [15:0] exp_cal(logic [15:0] spa, logic [15:0] zw, logic [15:0] sl, logic wm);
		logic [15:0] off;
		int          d;
		longint      p;
		off = wm ? {zw[10:0], 5'h00} : (zw[13] ? 16'h8000 - {zw[10:0], 5'h00} : 16'h8000 + {zw[10:0], 5'h00});
		d = sl[12] ? int'(off) - int'(spa) : int'(spa) - int'(off);
		d = wm ? d & 32'h0000FFFF : (d < 0 ? 0 : d);
		p = (longint'(d) * longint'(sl[11:0])) >>> 10;
		return p > 64'h000000000000FFFF ? 16'hFFFF : 16'(p);
	endfunction
	function automatic logic [15:0] exp_lin(logic [15:0] cal, pcl_corr_t c);
		int s;
		int a;
		int b;
		int r;
		s = int'(cal[15:13]);
		a = $signed(c[s]);
		b = $signed(c[s+1]);
		a = a < -127 ? -127 : a;
		b = b < -127 ? -127 : b;
		r = int'(cal) + ((a * 8192 + (b - a) * int'(cal[12:0])) >>> 8);
		return r < 0 ? 16'h0000 : (r > 32'h0000FFFF ? 16'hFFFF : 16'(r));
	endfunction

	// ==================================================
	// main sequence
	initial begin
		logic [15:0] zw, sl, k, cp, lp, sp, ec, el;
		logic        wm, e;
		pcl_corr_t   c;
		logic [31:0] q;
		rst();
		rd(PCL_IDX_ZERO, q, e);
		check(q, 32'h00002400);
		rd(PCL_IDX_SLOPE, q, e);
		check(q, 32'h00000400);
		for (int j = 0; j < 5; j++) begin
			rd(8'(PCL_IDX_PTW_LO + j), q, e);
			check(q, 32'h00000000);
		end
		rd(8'h02, q, e);
		check(e, 1'b1);
		for (int i = 0; i < 14; i++) begin
			case (i)
				0: begin zw = 16'h2400; sl = 16'h0400; wm = 1'b0; c = '0; end
				1: begin zw = 16'h2400; sl = 16'h0FFF; wm = 1'b0; c = {9{8'h7F}}; end
				2: begin zw = 16'h0000; sl = 16'h1400; wm = 1'b1; c = {9{8'h80}}; end
				default: begin
					zw = 16'($random(seed)) & 16'h27FF;
					sl = 16'($random(seed)) & 16'h1FFF;
					wm = 1'($random(seed));
					c = 72'({$random(seed), $random(seed), $random(seed)});
				end
			endcase
			k = (i == 1) ? 16'h4000 : (i == 2) ? v2code(2.5) : 16'($random(seed));
			wr(PCL_IDX_ZERO, {16'h0000, zw});
			wr(PCL_IDX_SLOPE, {16'h0000, sl | 16'hE000});
			wr(PCL_IDX_CTRL, {31'h00000000, wm});
			for (int j = 0; j < 5; j++) begin
				wr(8'(PCL_IDX_PTW_LO + j), j < 4 ? {16'h0000, c[2*j+1], c[2*j]} : {24'h000000, c[8]});
			end
			rd(PCL_IDX_SLOPE, q, e);
			check(q, {19'h00000, sl[12:0]});
			rd(PCL_IDX_ZERO, q, e);
			check(q, {16'h0000, zw});
			if (i == 2) begin
				rd(PCL_IDX_PTW_LO, q, e);
				check(q, 32'h00008181);
			end
			smp(k, 0, cp, lp);
			chk_ang(k, sp);
			ec = exp_cal(sp, zw, sl, wm);
			el = exp_lin(ec, c);
			check(cp, ec);
			check(lp, el);
			rd(PCL_IDX_LIN, q, e);
			check(q, {16'h0000, el});
			wr(PCL_IDX_CAL, 32'($random(seed)));
			rd(PCL_IDX_CAL, q, e);
			check(q, {16'h0000, ec});
			if (i == 0) begin
				check(cp, sp);
				check(lp, sp);
			end
		end
		wr(PCL_IDX_COILS, 32'h000000FF);
		rd(PCL_IDX_COILS, q, e);
		check(q, 32'h000000FC);
		wr(PCL_IDX_COILC, 32'h00000100);
		rd(PCL_IDX_COILC, q, e);
		check(q, 32'hFFFFFF04);
		wr(PCL_IDX_COILC, 32'h00000000);
		smp(16'h0000, 252, cp, lp);
		chk_ang(16'h0000, sp);
		rst();
		rd(PCL_IDX_ZERO, q, e);
		check(q, 32'h00002400);
		rd(PCL_IDX_COILS, q, e);
		check(q, 32'h00000000);
		tally_and_finish();
	end
endmodule
